/* File: design/mcw_pkg.sv */
/*
  Shared constants for the memory interconnect write and vector partner:
  timing counts at the 25 MHz core clock, widths and state encodings.
  Assumes a single clock domain with all pins synchronous to it.
*/
package mcw_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // latest times round down to whole cycles, never below one
  localparam int SEL_MAX_NS = 45;
  localparam int SEL_MAX_CYC = (SEL_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : SEL_MAX_NS / CLK_PERIOD_NS;
  localparam int HIT_MAX_NS = 100;
  localparam int HIT_MAX_CYC = (HIT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : HIT_MAX_NS / CLK_PERIOD_NS;
  localparam int BUF_FULL_MAX_NS = 50;
  localparam int BUF_FULL_MAX_CYC =
    (BUF_FULL_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : BUF_FULL_MAX_NS / CLK_PERIOD_NS;
  localparam int REPLY_NEG_MAX_NS = 300;
  localparam int REPLY_NEG_MAX_CYC =
    (REPLY_NEG_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : REPLY_NEG_MAX_NS / CLK_PERIOD_NS;
  localparam int VEC_MAX_NS = 75;
  localparam int VEC_MAX_CYC = (VEC_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : VEC_MAX_NS / CLK_PERIOD_NS;
  // least time rounds up
  localparam int PWR_HOLD_MS = 2;
  localparam int PWR_HOLD_CYC = (PWR_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_BUSY_CYC = 2;
  // address windows of the two responders
  localparam logic [21:0] MEM_BASE = 22'h000000;
  localparam logic [21:0] MEM_LIMIT = 22'h0FFFFF;
  localparam logic [21:0] LEGACY_BASE = 22'h100000;
  localparam logic [21:0] LEGACY_LIMIT = 22'h3BFFFF;
  localparam logic [3:0] REPLY_CNT_MAX = 4'(REPLY_NEG_MAX_CYC);
  localparam logic [3:0] BUSY_CNT_INIT = 4'(BUF_BUSY_CYC);

  typedef enum logic [4:0] {
    W_IDLE = 5'h01,
    W_ADDR = 5'h02,
    W_CYC = 5'h04,
    W_FULL = 5'h08,
    W_END = 5'h10
  } mcw_wstate_t;

  typedef enum logic [2:0] {
    V_IDLE = 3'h1,
    V_SERVE = 3'h2,
    V_DONE = 3'h4
  } mcw_vstate_t;
endpackage : mcw_pkg

/* File: design/mcw_partner.sv */
/*
  Partner end of the memory interconnect: memory slave and legacy bus adapter
  for word and byte write cycles, vector transfer from a legacy requester,
  and power_ok hold-off on ac_low.
  Assumes one 25 MHz clock, pins synchronous to it, the processor as master.
*/
`timescale 1ns/1ns
module mcw_partner #(
  parameter int PWR_HOLD = mcw_pkg::PWR_HOLD_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic native_bus_mode_in,
  input wire logic adapter_master_in,
  input wire logic [21:0] addr_data_lines_in,
  input wire logic io_page_select_in,
  input wire logic write_byte_ctl_in,
  input wire logic byte_xfer_in,
  input wire logic cycle_active_in,
  input wire logic write_strobe_in,
  input wire logic data_in_strobe_in,
  input wire logic int_ack_out_in,
  input wire logic vector_present_in,
  input wire logic legacy_bus_busy_in,
  input wire logic [15:0] legacy_vector_in,
  input wire logic ac_low_in,
  output logic slave_select_out,
  output logic bridge_memory_hit_out,
  output logic hit_captured_out,
  output logic slave_buffer_full_out,
  output logic reply_out,
  output logic [21:0] addr_data_lines_out,
  output logic addr_data_lines_oe_out,
  output logic legacy_slave_sync_out,
  output logic power_ok_out,
  output logic wr_valid_out,
  output logic [21:0] wr_addr_out,
  output logic [15:0] wr_data_out,
  output logic wr_byte_out
);
  localparam int PW = $clog2(PWR_HOLD + 1);

  function automatic logic in_window(input logic [21:0] a, input logic [21:0] lo,
                                     input logic [21:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction : in_window

  ////////////////////////////////////////////////////////////////////////////
  // write cycle responder
  mcw_pkg::mcw_wstate_t wstate, next_wstate;
  mcw_pkg::mcw_vstate_t vstate, next_vstate;
  logic next_sel, next_hit, next_hit_cap, next_full, next_reply, next_wr_valid, next_wr_byte;
  logic [21:0] next_wr_addr;
  logic [15:0] next_wr_data;
  logic [3:0] busy_cnt, next_busy_cnt, reply_cnt, next_reply_cnt;
  logic is_mem, is_legacy;

  always_comb begin
    is_mem = in_window(addr_data_lines_in, mcw_pkg::MEM_BASE, mcw_pkg::MEM_LIMIT);
    is_legacy = !is_mem &&
                in_window(addr_data_lines_in, mcw_pkg::LEGACY_BASE, mcw_pkg::LEGACY_LIMIT);
    next_wstate = wstate;
    next_sel = slave_select_out;
    next_hit = bridge_memory_hit_out;
    next_hit_cap = hit_captured_out;
    next_full = slave_buffer_full_out;
    next_wr_valid = 1'b0;
    next_wr_addr = wr_addr_out;
    next_wr_data = wr_data_out;
    next_wr_byte = wr_byte_out;
    next_busy_cnt = busy_cnt;
    case (wstate)
      mcw_pkg::W_IDLE: begin
        // decode one cycle after the address appears
        if (io_page_select_in && !cycle_active_in) begin
          next_sel = is_mem;
          next_hit = is_legacy;
          next_wr_addr = addr_data_lines_in;
          next_wr_byte = byte_xfer_in && write_byte_ctl_in;
          next_wstate = mcw_pkg::W_ADDR;
        end
      end
      mcw_pkg::W_ADDR: begin
        if (cycle_active_in) begin
          next_hit_cap = bridge_memory_hit_out;
          if (adapter_master_in && !slave_select_out && bridge_memory_hit_out) begin
            next_wstate = mcw_pkg::W_END;
          end else begin
            next_wstate = mcw_pkg::W_CYC;
          end
        end else if (!io_page_select_in) begin
          next_sel = 1'b0;
          next_hit = 1'b0;
          next_wstate = mcw_pkg::W_IDLE;
        end
      end
      mcw_pkg::W_CYC: begin
        if (write_strobe_in) begin
          // data is stable on the strobe edge, so take it here
          next_wr_data = addr_data_lines_in[15:0];
          next_wr_valid = 1'b1;
          next_full = 1'b1;
          next_busy_cnt = mcw_pkg::BUSY_CNT_INIT;
          next_wstate = mcw_pkg::W_FULL;
        end else if (!cycle_active_in) begin
          next_wstate = mcw_pkg::W_END;
        end
      end
      mcw_pkg::W_FULL: begin
        if (busy_cnt != 4'h0) begin
          next_busy_cnt = busy_cnt - 4'h1;
        end else begin
          next_full = 1'b0;
        end
        if (!cycle_active_in && busy_cnt == 4'h0) begin
          next_wstate = mcw_pkg::W_END;
        end
      end
      mcw_pkg::W_END: begin
        next_sel = 1'b0;
        next_hit = 1'b0;
        if (!cycle_active_in && !io_page_select_in) begin
          next_wstate = mcw_pkg::W_IDLE;
        end
      end
      default: next_wstate = mcw_pkg::W_IDLE;
    endcase
    // one reply flop serves both the write cycle and the vector transfer
    next_reply_cnt = 4'h0;
    next_reply = 1'b0;
    if (next_vstate == mcw_pkg::V_SERVE) begin
      next_reply = 1'b1;
    end else if (native_bus_mode_in && cycle_active_in &&
                 (next_wstate == mcw_pkg::W_CYC || next_wstate == mcw_pkg::W_FULL)) begin
      // forced down before the limit even if the master lingers
      next_reply = reply_cnt < mcw_pkg::REPLY_CNT_MAX;
      next_reply_cnt = (reply_cnt < mcw_pkg::REPLY_CNT_MAX) ? reply_cnt + 4'h1 : reply_cnt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wstate <= mcw_pkg::W_IDLE;
      slave_select_out <= 1'b0;
      bridge_memory_hit_out <= 1'b0;
      hit_captured_out <= 1'b0;
      slave_buffer_full_out <= 1'b0;
      reply_out <= 1'b0;
      reply_cnt <= 4'h0;
      busy_cnt <= 4'h0;
      wr_valid_out <= 1'b0;
      wr_addr_out <= 22'h000000;
      wr_data_out <= 16'h0000;
      wr_byte_out <= 1'b0;
    end else begin
      wstate <= next_wstate;
      slave_select_out <= next_sel;
      bridge_memory_hit_out <= next_hit;
      hit_captured_out <= next_hit_cap;
      slave_buffer_full_out <= next_full;
      reply_out <= next_reply;
      reply_cnt <= next_reply_cnt;
      busy_cnt <= next_busy_cnt;
      wr_valid_out <= next_wr_valid;
      wr_addr_out <= next_wr_addr;
      wr_data_out <= next_wr_data;
      wr_byte_out <= next_wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector transfer
  logic next_sync, next_oe;
  logic [21:0] next_lines;

  always_comb begin
    next_vstate = vstate;
    next_sync = legacy_slave_sync_out;
    next_oe = addr_data_lines_oe_out;
    next_lines = addr_data_lines_out;
    case (vstate)
      mcw_pkg::V_IDLE: begin
        // requester already owns the legacy bus and has its vector up
        if (vector_present_in && legacy_bus_busy_in && int_ack_out_in && data_in_strobe_in) begin
          next_lines = {6'h00, legacy_vector_in};
          next_oe = 1'b1;
          next_sync = 1'b1;
          next_vstate = mcw_pkg::V_SERVE;
        end
      end
      mcw_pkg::V_SERVE: begin
        if (!vector_present_in) begin
          next_sync = 1'b0;
        end
        if (!int_ack_out_in) begin
          next_oe = 1'b0;
          next_vstate = mcw_pkg::V_DONE;
        end
      end
      mcw_pkg::V_DONE: begin
        if (!vector_present_in) begin
          next_sync = 1'b0;
        end
        if (!vector_present_in && !legacy_bus_busy_in && !int_ack_out_in) begin
          next_vstate = mcw_pkg::V_IDLE;
        end
      end
      default: next_vstate = mcw_pkg::V_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vstate <= mcw_pkg::V_IDLE;
      legacy_slave_sync_out <= 1'b0;
      addr_data_lines_oe_out <= 1'b0;
      addr_data_lines_out <= 22'h000000;
    end else begin
      vstate <= next_vstate;
      legacy_slave_sync_out <= next_sync;
      addr_data_lines_oe_out <= next_oe;
      addr_data_lines_out <= next_lines;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power_ok hold-off
  logic [PW-1:0] pwr_cnt, next_pwr_cnt;
  logic next_pok;

  always_comb begin
    next_pwr_cnt = '0;
    next_pok = 1'b1;
    if (ac_low_in) begin
      // software gets the full hold time before power_ok falls
      if (pwr_cnt < PW'(PWR_HOLD)) begin
        next_pwr_cnt = pwr_cnt + PW'(1);
      end else begin
        next_pwr_cnt = pwr_cnt;
        next_pok = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pwr_cnt <= '0;
      power_ok_out <= 1'b1;
    end else begin
      pwr_cnt <= next_pwr_cnt;
      power_ok_out <= next_pok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [PW-1:0] ac_run;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !ac_low_in) begin
      ac_run <= '0;
    end else if (ac_run < PW'(PWR_HOLD)) begin
      ac_run <= ac_run + PW'(1);
    end
  end

  sequence s_vec_start;
    vstate == mcw_pkg::V_IDLE && vector_present_in && legacy_bus_busy_in && int_ack_out_in &&
      data_in_strobe_in;
  endsequence
  sequence s_vec_up;
    reply_out && addr_data_lines_oe_out && legacy_slave_sync_out &&
      addr_data_lines_out[15:0] == $past(legacy_vector_in);
  endsequence

  chk_select_decode: assert property (
    wstate == mcw_pkg::W_IDLE && io_page_select_in && !cycle_active_in && is_mem
    |=> slave_select_out && !bridge_memory_hit_out)
    else $error("slave_select late or wrong for memory address");
  chk_hit_decode: assert property (
    wstate == mcw_pkg::W_IDLE && io_page_select_in && !cycle_active_in && is_legacy
    |-> ##[1:2] bridge_memory_hit_out)
    else $error("bridge_memory_hit not raised in time");
  chk_hit_capture: assert property (
    wstate == mcw_pkg::W_ADDR && cycle_active_in
    |=> hit_captured_out == $past(bridge_memory_hit_out))
    else $error("hit not captured at cycle start");
  chk_abort_quiet: assert property (
    wstate == mcw_pkg::W_ADDR && cycle_active_in && adapter_master_in && !slave_select_out &&
    bridge_memory_hit_out |=> wstate == mcw_pkg::W_END && !reply_out)
    else $error("adapter did not abort its own cycle");
  chk_reply_native: assert property (
    wstate == mcw_pkg::W_ADDR && cycle_active_in && !adapter_master_in && native_bus_mode_in &&
    vstate == mcw_pkg::V_IDLE ##1 cycle_active_in |-> reply_out)
    else $error("reply missing in native mode");
  chk_full_timing: assert property (
    wstate == mcw_pkg::W_CYC && write_strobe_in |=> slave_buffer_full_out && wr_valid_out)
    else $error("buffer full late after write strobe");
  chk_reply_limit: assert property (
    vstate == mcw_pkg::V_IDLE && reply_out [*7] |=> !reply_out)
    else $error("write reply held too long");
  chk_vector_serve: assert property (
    s_vec_start |=> s_vec_up)
    else $error("vector not latched and driven with reply");
  chk_reply_wait: assert property (
    vstate == mcw_pkg::V_SERVE && int_ack_out_in |=> reply_out)
    else $error("reply dropped before int_ack_out fell");
  chk_power_hold: assert property (
    ac_low_in && ac_run < PW'(PWR_HOLD) |=> power_ok_out)
    else $error("power_ok dropped before hold time");
endmodule : mcw_partner

/* File: test/mcw_master_model.sv */
/*
  Processor-side master model: word/byte write cycles and vector fetch.
  Assumes one 25 MHz clock and tasks called from a single bench process.
*/
`timescale 1ns/1ns
module mcw_master_model (
  input wire logic clk_in,
  input wire logic full_in,
  input wire logic sel_in,
  input wire logic hit_in,
  input wire logic reply_in,
  input wire logic [21:0] lines_in,
  output logic [21:0] lines_out,
  output logic iops_out,
  output logic wbc_out,
  output logic byte_out,
  output logic cyc_out,
  output logic strobe_out,
  output logic din_out,
  output logic iack_out
);
  logic sel_seen;
  logic hit_seen;
  logic [15:0] vec_seen;

  initial begin
    lines_out = 22'h000000;
    {iops_out, wbc_out, byte_out, cyc_out, strobe_out, din_out, iack_out} = 7'h00;
  end

  task automatic write_cycle(input logic [21:0] addr, input logic [15:0] data, input logic bw);
    int n;
    n = 0;
    @(posedge clk_in);
    while (full_in !== 1'b0 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    lines_out <= addr;
    iops_out <= 1'b1;
    wbc_out <= 1'b1;
    byte_out <= bw;
    // both responders settle before the path is chosen
    repeat (mcw_pkg::HIT_MAX_CYC) @(posedge clk_in);
    sel_seen = sel_in;
    hit_seen = hit_in;
    cyc_out <= 1'b1;
    @(posedge clk_in);
    lines_out <= {6'h00, data};
    strobe_out <= 1'b1;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    @(posedge clk_in);
    cyc_out <= 1'b0;
    lines_out <= ~lines_out;
    @(posedge clk_in);
    iops_out <= 1'b0;
    wbc_out <= 1'b0;
    byte_out <= 1'b0;
  endtask : write_cycle

  task automatic vector_fetch();
    int n;
    n = 0;
    @(posedge clk_in);
    din_out <= 1'b1;
    iack_out <= 1'b1;
    @(posedge clk_in);
    while (reply_in !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    vec_seen = lines_in[15:0];
    din_out <= 1'b0;
    iack_out <= 1'b0;
  endtask : vector_fetch
endmodule : mcw_master_model

/* File: test/tb_memory_interconnect_write_vector.sv */
/*
  Self-checking bench for the memory slave and legacy adapter partner.
  Assumes the master model beside it; the bench plays the legacy requester.
*/
`timescale 1ns/1ns
module tb_memory_interconnect_write_vector;
  localparam int PWR = 20;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic native_bus_mode_in = 1'b1;
  logic adapter_master_in = 1'b0;
  logic vector_present_in = 1'b0;
  logic legacy_bus_busy_in = 1'b0;
  logic [15:0] legacy_vector_in = 16'h0000;
  logic ac_low_in = 1'b0;
  wire [21:0] lines;
  wire [21:0] m_lines;
  wire iops, wbc, bx, cyc, wstb, din, iack;
  logic sel, hit, cap, full, reply, oe, sync, pok, wrv, wbyte;
  logic [21:0] dut_lines;
  logic [21:0] wr_addr;
  logic [15:0] wr_data;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic reply_seen, full_seen, sync_seen;
  int wrv_cnt;

  always #20 core_clk_in = ~core_clk_in;
  // the adapter owns the lines only while it drives the vector
  assign lines = (oe === 1'b1) ? dut_lines : m_lines;

  mcw_partner #(.PWR_HOLD(PWR)) i_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .native_bus_mode_in(native_bus_mode_in), .adapter_master_in(adapter_master_in),
    .addr_data_lines_in(lines), .io_page_select_in(iops), .write_byte_ctl_in(wbc),
    .byte_xfer_in(bx), .cycle_active_in(cyc), .write_strobe_in(wstb),
    .data_in_strobe_in(din), .int_ack_out_in(iack), .vector_present_in(vector_present_in),
    .legacy_bus_busy_in(legacy_bus_busy_in), .legacy_vector_in(legacy_vector_in),
    .ac_low_in(ac_low_in), .slave_select_out(sel), .bridge_memory_hit_out(hit),
    .hit_captured_out(cap), .slave_buffer_full_out(full), .reply_out(reply),
    .addr_data_lines_out(dut_lines), .addr_data_lines_oe_out(oe),
    .legacy_slave_sync_out(sync), .power_ok_out(pok), .wr_valid_out(wrv),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_byte_out(wbyte));

  mcw_master_model i_master (
    .clk_in(core_clk_in), .full_in(full), .sel_in(sel), .hit_in(hit), .reply_in(reply),
    .lines_in(lines), .lines_out(m_lines), .iops_out(iops), .wbc_out(wbc), .byte_out(bx),
    .cyc_out(cyc), .strobe_out(wstb), .din_out(din), .iack_out(iack));

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (reply === 1'b1) reply_seen <= 1'b1;
    if (full === 1'b1) full_seen <= 1'b1;
    if (sync === 1'b1) sync_seen <= 1'b1;
    if (wrv === 1'b1) wrv_cnt <= wrv_cnt + 1;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic clear_seen();
    @(posedge core_clk_in);
    {reply_seen, full_seen, sync_seen} = 3'h0;
    wrv_cnt = 0;
  endtask : clear_seen

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_writes();
    logic [21:0] a [4] = '{22'h000100, 22'h0FFFFF, 22'h100000, 22'h3C0000};
    logic h;
    for (int i = 0; i < 4; i++) begin
      native_bus_mode_in <= (i < 2);
      h = (i == 2);
      clear_seen();
      i_master.write_cycle(a[i], 16'hA5C0 + 16'(i), i == 1);
      repeat (2) @(posedge core_clk_in);
      check("select", 22'(i < 2), 22'(i_master.sel_seen));
      check("hit", 22'(h), 22'(i_master.hit_seen));
      // the captured copy stands until the next cycle start, so read it, not a sticky flag
      check("hit capture", 22'(h), 22'(cap));
      check("reply", 22'(i < 2), 22'(reply_seen));
      check("buffer full", 22'h000001, 22'(full_seen));
      check("writes taken", 22'h000001, 22'(wrv_cnt));
      check("write addr", a[i], wr_addr);
      check("write data", 22'(16'hA5C0 + 16'(i)), 22'(wr_data));
      check("byte flag", 22'(i == 1), 22'(wbyte));
      check("reply end", 22'h000000, 22'(reply));
      check("full end", 22'h000000, 22'(full));
    end
  endtask : t_writes

  task automatic t_abort();
    native_bus_mode_in <= 1'b1;
    adapter_master_in <= 1'b1;
    clear_seen();
    i_master.write_cycle(22'h100040, 16'h0F0F, 1'b0);
    repeat (2) @(posedge core_clk_in);
    check("abort reply", 22'h000000, 22'(reply_seen));
    check("abort full", 22'h000000, 22'(full_seen));
    check("abort write", 22'h000000, 22'(wrv_cnt));
    adapter_master_in <= 1'b0;
  endtask : t_abort

  task automatic t_vector();
    int n;
    n = 0;
    clear_seen();
    fork
      begin
        legacy_bus_busy_in <= 1'b1;
        legacy_vector_in <= 16'h01B4;
        @(posedge core_clk_in);
        vector_present_in <= 1'b1;
        while (sync !== 1'b1 && n < 20) begin
          @(posedge core_clk_in);
          n++;
        end
        vector_present_in <= 1'b0;
        legacy_vector_in <= 16'hFE4B;
        @(posedge core_clk_in);
        legacy_bus_busy_in <= 1'b0;
      end
      i_master.vector_fetch();
    join
    repeat (3) @(posedge core_clk_in);
    check("vector", 22'h0001B4, 22'(i_master.vec_seen));
    check("sync seen", 22'h000001, 22'(sync_seen));
    check("sync end", 22'h000000, 22'(sync));
    check("vector reply end", 22'h000000, 22'(reply));
    check("lines released", 22'h000000, 22'(oe));
  endtask : t_vector

  task automatic t_power();
    int n;
    n = 0;
    ac_low_in <= 1'b1;
    @(posedge core_clk_in);
    while (pok === 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      n++;
    end
    // up to two cycles of slack above the hold time, none below, for the registered input and output
    check("hold long enough", 22'h000001, 22'(n >= PWR && n <= PWR + 2));
    ac_low_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    check("power ok back", 22'h000001, 22'(pok));
  endtask : t_power

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    check("reset power ok", 22'h000001, 22'(pok));
    check("reset reply", 22'h000000, 22'({reply, sel, hit, full, oe, sync}));
    t_writes();
    t_abort();
    t_vector();
    t_power();
    wrap_up();
  end
endmodule : tb_memory_interconnect_write_vector
